// File: rtl/xdm_stretch.sv
`timescale 1ns/1ns
// Notes on behaviour
// [R1] each move opens with a 4-clock fetch
// [R2] next cycle drives address and does access
// [R3] stretch comes from control register bits 2:0
// [R4] move lasts stretch plus two machine cycles
// [R5] only moves stretch; cpu held meanwhile
// [R6] stretch is 1 after reset
// [R7] strobe 2 clocks, else 4 per step
// [R8] hold input is port four bit zero
// [R9] hold honoured only when enable bit set
// [R10] stretch is the minimum move length
// [R11] hold sampled at third state before strobe end
// [R12] active sample adds one machine cycle
// [R13] waits unlimited; ends when hold inactive
// [R14] enable bit written only after unlock
// [R15] four clock states per machine cycle
// [R16] indirect address is port2 and working reg
// [R17] pointer select bit0 picks data pointer
// [R18] peripheral asserts hold before the sample
// [R19] read strobe for reads, write for writes
module xdm_stretch
  import xdm_pkg::*;
#(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [xdm_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic fourth_port_bit_zero,
  input wire logic [7:0] ext_data_in,
  output xdm_pkg::ext_out_t ext_out,
  output logic cpu_hold
);
  import xdm_pkg::*;

  // ---------------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rst_pipe;
  logic rst_n;
  logic hold_pin;
  logic [7:0] data_pin;

  // reset asserts at once and leaves after two edges
  // one shared copy lets every flop leave reset on the same edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  sync2 #(.WIDTH(1)) u_hold_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(fourth_port_bit_zero), // [R8]
    .q(hold_pin)
  );

  // eight bits through plain synchronisers is safe only because the bus
  // is read after it has stood still under the strobe for at least one clock
  sync2 #(.WIDTH(8)) u_data_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(ext_data_in),
    .q(data_pin)
  );

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  logic [2:0] stretch_select;
  logic hold_input_enable;
  logic pointer_select;
  logic [15:0] first_data_pointer;
  logic [15:0] second_data_pointer;
  logic [7:0] port2_latch;
  logic [7:0] working_reg;
  logic [7:0] read_byte;
  logic [7:0] last_cycles;
  logic ta_armed;
  logic [7:0] ta_window;
  logic bus_ack;
  logic req;
  logic cmd_hit;
  logic cmd_stall;
  logic wr_take;
  logic busy;
  logic start;

  assign req = avs_read | avs_write;
  assign cmd_hit = avs_write && (avs_address == OFF_COMMAND);
  // a new move waits on the bus until the previous one finishes
  assign cmd_stall = cmd_hit && busy;
  assign avs_waitrequest = req && (!bus_ack || cmd_stall);
  assign wr_take = avs_write && bus_ack && !cmd_stall;
  assign start = wr_take && (avs_address == OFF_COMMAND);

  // one wait cycle per access, more for a command during a move, so read data comes from a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= req && !bus_ack && !cmd_stall;
    end
  end

  // plain configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stretch_select <= STRETCH_RESET; // [R6]
      pointer_select <= 1'b0;
      first_data_pointer <= 16'h0000;
      second_data_pointer <= 16'h0000;
      port2_latch <= 8'h00;
      working_reg <= 8'h00;
    end else if (wr_take) begin
      unique case (avs_address)
        OFF_CLOCK_CONTROL: stretch_select <= avs_writedata[STRETCH_LSB +: 3]; // [R3]
        OFF_POINTER_SELECT: pointer_select <= avs_writedata[0]; // [R17]
        OFF_FIRST_POINTER: first_data_pointer <= avs_writedata[15:0];
        OFF_SECOND_POINTER: second_data_pointer <= avs_writedata[15:0];
        OFF_PORT2_LATCH: port2_latch <= avs_writedata[7:0];
        OFF_WORKING_REG: working_reg <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  // unlock: key1 then key2 opens a short window for the enable bit
  // any other register write between the keys disarms the unlock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ta_armed <= 1'b0;
      ta_window <= 8'h00;
      hold_input_enable <= 1'b0;
    end else begin
      if (ta_window != 8'h00) begin
        ta_window <= ta_window - 8'h01;
      end
      if (wr_take && avs_address == OFF_TIMED_ACCESS) begin
        ta_armed <= (avs_writedata[7:0] == TA_KEY1);
        if (ta_armed && avs_writedata[7:0] == TA_KEY2) begin
          ta_window <= 8'(TA_WINDOW_CLOCKS);
        end
      end else if (wr_take) begin
        ta_armed <= 1'b0;
      end
      if (wr_take && avs_address == OFF_MEMORY_MAP) begin
        if (ta_window != 8'h00) begin
          hold_input_enable <= avs_writedata[HOLD_EN_BIT]; // [R14]
          ta_window <= 8'h00;
        end
      end
    end
  end

  // read data is registered in the wait cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !bus_ack) begin
      unique case (avs_address)
        OFF_CLOCK_CONTROL: avs_readdata <= {29'h0000_0000, stretch_select};
        OFF_MEMORY_MAP: avs_readdata <= {24'h00_0000, hold_input_enable, 7'h00};
        OFF_TIMED_ACCESS: avs_readdata <= {31'h0000_0000, ta_window != 8'h00};
        OFF_FIRST_POINTER: avs_readdata <= {16'h0000, first_data_pointer};
        OFF_SECOND_POINTER: avs_readdata <= {16'h0000, second_data_pointer};
        OFF_PORT2_LATCH: avs_readdata <= {24'h00_0000, port2_latch};
        OFF_WORKING_REG: avs_readdata <= {24'h00_0000, working_reg};
        OFF_STATUS: avs_readdata <= {8'h00, last_cycles, read_byte, 7'h00, busy};
        OFF_POINTER_SELECT: avs_readdata <= {31'h0000_0000, pointer_select};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // move sequencer
  // ---------------------------------------------------------------
  seq_state_t state;
  logic [1:0] phase;
  logic [7:0] cyc;
  logic [7:0] last;
  logic [2:0] mv_stretch;
  logic mv_write;
  logic [15:0] mv_addr;
  logic [7:0] mv_wdata;
  logic [7:0] sample_cyc;
  logic hold_live;
  logic hold_hit;
  logic strobe;
  logic strobe_end;
  logic [15:0] next_addr;
  logic [1:0] capture_pipe;

  assign busy = (state != SEQ_IDLE);
  assign cpu_hold = busy; // [R5]
  assign hold_live = LARGE_PACKAGE && hold_input_enable && hold_pin; // [R9]

  // indirect form uses port2 and working reg, else the chosen pointer
  always_comb begin
    if (avs_writedata[CMD_POINTER_BIT]) begin
      next_addr = pointer_select ? second_data_pointer : first_data_pointer; // [R17]
    end else begin
      next_addr = {port2_latch, working_reg}; // [R16]
    end
  end

  // hold is looked at in the third state just before the strobe ends
  // a hold raised after the last sample point is not seen by this move
  assign sample_cyc = (mv_stretch == 3'h0) ? last : last - 8'h01; // [R11]
  assign hold_hit = (state == SEQ_ACCESS) && (phase == PH_C3) &&
                    (cyc == sample_cyc) && hold_live; // [R18]

  // strobe: stretch 0 runs C2..C3, otherwise C3 of first to C2 of last
  // waits add whole machine cycles to either shape
  always_comb begin
    strobe = 1'b0;
    strobe_end = 1'b0;
    if (state == SEQ_ACCESS) begin
      if (mv_stretch == 3'h0) begin
        strobe = ((cyc == 8'h01) && (phase >= PH_C2)) ||
                 ((cyc > 8'h01) && (cyc < last)) ||
                 ((cyc == last) && (cyc > 8'h01) && (phase <= PH_C3)) ||
                 ((cyc == 8'h01) && (last == 8'h01) && (phase == PH_C2)); // [R7]
        if (last == 8'h01) begin
          strobe = (phase == PH_C2) || (phase == PH_C3);
        end
        strobe_end = (cyc == last) && (phase == PH_C3) && !hold_hit;
      end else begin
        strobe = ((cyc == 8'h01) && (phase >= PH_C3)) ||
                 ((cyc > 8'h01) && (cyc < last)) ||
                 ((cyc == last) && (phase <= PH_C2)); // [R7]
        strobe_end = (cyc == last) && (phase == PH_C2);
      end
    end
  end

  // state register and clock-state counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SEQ_IDLE;
      phase <= PH_C1;
      cyc <= 8'h00;
    end else begin
      unique case (state)
        SEQ_IDLE: begin
          phase <= PH_C1;
          cyc <= 8'h00;
          if (start) begin
            state <= SEQ_FETCH; // [R1]
          end
        end
        SEQ_FETCH: begin
          phase <= phase + 2'h1; // [R15]
          if (phase == PH_C4) begin
            state <= SEQ_ACCESS; // [R2]
            cyc <= 8'h01;
          end
        end
        SEQ_ACCESS: begin
          phase <= phase + 2'h1;
          if (phase == PH_C4) begin
            if (cyc == last && !hold_hit) begin
              state <= SEQ_IDLE; // [R13]
            end else begin
              cyc <= cyc + 8'h01;
            end
          end
        end
      endcase
    end
  end

  // latch the move and extend it on each held sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mv_stretch <= STRETCH_RESET;
      mv_write <= 1'b0;
      mv_addr <= 16'h0000;
      mv_wdata <= 8'h00;
      last <= 8'h00;
    end else if (start) begin
      mv_stretch <= stretch_select;
      mv_write <= avs_writedata[CMD_WRITE_BIT];
      mv_addr <= next_addr;
      mv_wdata <= avs_writedata[CMD_DATA_LSB +: 8];
      last <= {5'h00, stretch_select} + 8'h01; // [R4] [R10]
    end else if (hold_hit) begin
      last <= last + 8'h01; // [R12] [R13]
    end
  end

  // strobe end delayed by the pin register and one sync stage; taking the
  // byte at the internal strobe end would miss a 2-clock strobe entirely
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_pipe <= 2'b00;
    end else begin
      capture_pipe <= {capture_pipe[0], strobe_end && !mv_write};
    end
  end

  // result byte and length of the finished move
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      read_byte <= 8'h00;
      last_cycles <= 8'h00;
    end else begin
      if (capture_pipe[1]) begin
        read_byte <= data_pin; // bus as it stood under the strobe [R19]
      end
      if (state == SEQ_ACCESS && phase == PH_C4 && cyc == last && !hold_hit) begin
        last_cycles <= last + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // external pins, all from flops
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_out <= '{addr: 16'h0000, wdata: 8'h00, data_oe: 1'b0, rd_n: 1'b1, wr_n: 1'b1};
    end else begin
      ext_out.addr <= mv_addr;
      ext_out.wdata <= mv_wdata;
      ext_out.data_oe <= (state == SEQ_ACCESS) && mv_write;
      ext_out.rd_n <= !(strobe && !mv_write); // [R19]
      ext_out.wr_n <= !(strobe && mv_write); // [R19]
    end
  end

endmodule

// File: rtl/xdm_pkg.sv
package xdm_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int STATES_PER_CYCLE = 4;
  localparam logic [1:0] PH_C1 = 2'h0;
  localparam logic [1:0] PH_C2 = 2'h1;
  localparam logic [1:0] PH_C3 = 2'h2;
  localparam logic [1:0] PH_C4 = 2'h3;
  // unlock window after the second key byte, in ns and in clocks
  localparam int TA_WINDOW_NS = 480;
  localparam int TA_WINDOW_CLOCKS = (TA_WINDOW_NS * CLK_MHZ) / 1000;

  // ---------------------------------------------------------------
  // register byte offsets (avalon byte address, word aligned), plus one word index
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFF_CLOCK_CONTROL = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_MEMORY_MAP = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_TIMED_ACCESS = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_FIRST_POINTER = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_SECOND_POINTER = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_PORT2_LATCH = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_WORKING_REG = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_COMMAND = 12'h01C;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h020;
  localparam logic [ADDR_W-1:0] IDX_POINTER_SELECT = 12'h086;
  localparam logic [ADDR_W-1:0] OFF_POINTER_SELECT = 12'h218;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int STRETCH_LSB = 0;
  localparam int HOLD_EN_BIT = 7;
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_POINTER_BIT = 1;
  localparam int CMD_DATA_LSB = 8;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DATA_LSB = 8;
  localparam int ST_CYCLES_LSB = 16;
  localparam logic [2:0] STRETCH_RESET = 3'h1;
  localparam logic [7:0] TA_KEY1 = 8'hAA;
  localparam logic [7:0] TA_KEY2 = 8'h55;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_FETCH,
    SEQ_ACCESS
  } seq_state_t;

  // pins toward external data memory
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic data_oe;
    logic rd_n;
    logic wr_n;
  } ext_out_t;

endpackage

// File: rtl/sync2.sv
`timescale 1ns/1ns
// two-flop synchroniser; first stage feeds only the second
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  // reset to zero; both stages clock every edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// File: tb/xdm_stretch_props.sv
`timescale 1ns/1ns
module xdm_stretch_props
  import xdm_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [xdm_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic fourth_port_bit_zero,
  input wire logic [7:0] ext_data_in,
  input wire xdm_pkg::ext_out_t ext_out,
  input wire logic cpu_hold
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [7:0] low_len;
  logic [7:0] run_len;
  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  // strobe width; saturates so a long wait cannot wrap into a legal value
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_len <= 8'h00;
    end else if (ext_out.rd_n && ext_out.wr_n) begin
      low_len <= 8'h00;
    end else if (low_len != 8'hFF) begin
      low_len <= low_len + 8'h01;
    end
  end
  // move length in clocks
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_len <= 8'h00;
    end else if (!cpu_hold) begin
      run_len <= 8'h00;
    end else if (run_len != 8'hFF) begin
      run_len <= run_len + 8'h01;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  rd_wr_excl_a: assert property (ext_out.rd_n || ext_out.wr_n)
    else $error("both strobes low");
  fetch_first_a: assert property ($rose(cpu_hold) |-> (ext_out.rd_n && ext_out.wr_n)[*5])
    else $error("strobe during fetch");
  min_length_a: assert property ($rose(cpu_hold) |-> cpu_hold[*8])
    else $error("move shorter than two cycles");
  strobe_width_a: assert property ($rose(ext_out.rd_n && ext_out.wr_n) |->
    (low_len == 8'h02 || (low_len[1:0] == 2'h0 && low_len >= 8'h04)))
    else $error("strobe width off grid");
  run_length_a: assert property ($fell(cpu_hold) |-> run_len >= 8'h08 && run_len[1:0] == 2'h0)
    else $error("move not whole machine cycles");
  oe_read_excl_a: assert property (ext_out.data_oe |-> ext_out.rd_n)
    else $error("driving bus during read");
  strobe_in_move_a: assert property (!(ext_out.rd_n && ext_out.wr_n) |-> cpu_hold)
    else $error("strobe outside move");
  addr_hold_a: assert property (!(ext_out.rd_n && ext_out.wr_n)
    && !$past(ext_out.rd_n && ext_out.wr_n) |-> $stable(ext_out.addr))
    else $error("address moved under strobe");
endmodule

bind xdm_stretch xdm_stretch_props props_i (.clk(clk), .rstn(rstn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .fourth_port_bit_zero(fourth_port_bit_zero), .ext_data_in(ext_data_in),
  .ext_out(ext_out), .cpu_hold(cpu_hold));

// File: tb/ext_peer.sv
`timescale 1ns/1ns
module ext_peer
  import xdm_pkg::*;
(
  input wire logic clk,
  input wire xdm_pkg::ext_out_t ext_out,
  input wire logic [3:0] slow_k,
  output logic [7:0] ext_data_in,
  output logic hold_pin
);
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'h00;
  logic [3:0] prev_k = 4'h0;
  int low_cnt = 0;
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  // released bus shows the inverse of the last byte, never a stale copy
  assign ext_data_in = !ext_out.rd_n ? mem[ext_out.addr] : ~last;
  // write byte taken on every strobe clock; last one wins
  always @(posedge clk) begin
    if (!ext_out.rd_n) last <= mem[ext_out.addr];
    if (!ext_out.wr_n && ext_out.data_oe) mem[ext_out.addr] <= ext_out.wdata;
  end
  // ---------------------------------------------------------------
  // slow peripheral
  // ---------------------------------------------------------------
  // hold is up before the move starts and drops mid-cycle, away from any sample
  always @(posedge clk) begin
    prev_k <= slow_k;
    if (slow_k != prev_k) low_cnt <= 0;
    else if (!(ext_out.rd_n && ext_out.wr_n)) low_cnt <= low_cnt + 1;
  end
  assign hold_pin = (slow_k != 4'h0) && (low_cnt < 4 * slow_k - 2);
endmodule

// File: tb/xdm_stretch_tb.sv
`timescale 1ns/1ns
module xdm_stretch_tb;
  import xdm_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic hold_pin;
  logic [7:0] ext_data_in;
  ext_out_t ext_out;
  logic cpu_hold;
  logic [3:0] slow_k = 4'h0;
  logic [15:0] a;
  logic [7:0] d;
  int err_count = 0;
  int total_checks = 0;
  int run = 0;
  logic [31:0] rd_exp[$];
  logic [31:0] rd_msk[$];
  logic [31:0] len_exp[$];
  // ---------------------------------------------------------------
  // design and far side
  // ---------------------------------------------------------------
  xdm_stretch xdm_stretch_i (.clk(clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fourth_port_bit_zero(hold_pin), .ext_data_in(ext_data_in),
    .ext_out(ext_out), .cpu_hold(cpu_hold));
  ext_peer ext_peer_i (.clk(clk), .ext_out(ext_out), .slow_k(slow_k),
    .ext_data_in(ext_data_in), .hold_pin(hold_pin));
  // 25 MHz
  always #20 clk = ~clk;
  // ---------------------------------------------------------------
  // checking
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && total_checks > 0 && len_exp.size() == 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // read answers against the notes left by the bus task
  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      check(avs_readdata & rd_msk.pop_front(), rd_exp.pop_front());
    end
  end
  // each move's length in clocks against its note
  always @(posedge clk) begin
    if (cpu_hold === 1'b1) begin
      run <= run + 1;
    end else if (run != 0) begin
      check(32'(run), len_exp.pop_front());
      run <= 0;
    end
  end
  // ---------------------------------------------------------------
  // drivers
  // ---------------------------------------------------------------
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] ad, input logic [31:0] dt,
                     input logic [31:0] m);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= ad;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= dt;
    if (!wr) begin
      rd_exp.push_back(dt & m);
      rd_msk.push_back(m);
    end
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 200);
    if (avs_waitrequest !== 1'b0) begin
      err_count++;
      end_of_test();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // one move; w is the number of wait cycles the hold pin should add
  task automatic move(input logic [2:0] s, input logic [3:0] k, input logic wm,
                      input logic pm, input int w);
    int n;
    n = 0;
    slow_k <= 4'h0;
    bus(1'b1, OFF_CLOCK_CONTROL, {29'h0, s}, 32'h0);
    slow_k <= k;
    len_exp.push_back(32'(4 * (s + 2 + w)));
    bus(1'b1, OFF_COMMAND, {16'h0, d, 6'h0, pm, wm}, 32'h0);
    repeat (2) @(posedge clk);
    while (cpu_hold !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) begin
      err_count++;
      end_of_test();
    end
    bus(1'b0, OFF_STATUS, {8'h0, 8'(s + 2 + w), d, 8'h00},
        wm ? 32'h00FF_0000 : 32'h00FF_FF00);
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h54c1_2c62));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b0, OFF_CLOCK_CONTROL, 32'h0000_0001, 32'h0000_0007);
    bus(1'b0, 12'hFFC, 32'h0000_0000, 32'hFFFF_FFFF);
    bus(1'b1, OFF_MEMORY_MAP, 32'h0000_0080, 32'h0);
    bus(1'b0, OFF_MEMORY_MAP, 32'h0000_0000, 32'h0000_0080);
    bus(1'b1, OFF_POINTER_SELECT, 32'h0000_0001, 32'h0);
    // write indirectly, read back through the second pointer
    for (int s = 0; s < 8; s++) begin
      a = 16'($urandom);
      d = 8'($urandom);
      bus(1'b1, OFF_PORT2_LATCH, {24'h0, a[15:8]}, 32'h0);
      bus(1'b1, OFF_WORKING_REG, {24'h0, a[7:0]}, 32'h0);
      bus(1'b1, OFF_SECOND_POINTER, {16'h0, a}, 32'h0);
      move(3'(s), 4'h0, 1'b1, 1'b0, 0);
      move(3'(s), 4'h0, 1'b0, 1'b1, 0);
    end
    move(3'h2, 4'h3, 1'b1, 1'b1, 0);
    bus(1'b1, OFF_TIMED_ACCESS, {24'h0, TA_KEY1}, 32'h0);
    bus(1'b1, OFF_TIMED_ACCESS, {24'h0, TA_KEY2}, 32'h0);
    bus(1'b1, OFF_MEMORY_MAP, 32'h0000_0080, 32'h0);
    bus(1'b0, OFF_MEMORY_MAP, 32'h0000_0080, 32'h0000_0080);
    move(3'h1, 4'h1, 1'b0, 1'b1, 2);
    move(3'h2, 4'h3, 0, 1'b1, 3);
    move(3'h3, 4'h1, 1'b0, 1'b1, 0);
    // a second reset mid-run must restore stretch 1 and clear the enable
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b0, OFF_CLOCK_CONTROL, 32'h0000_0001, 32'h0000_0007);
    bus(1'b0, OFF_MEMORY_MAP, 32'h0000_0000, 32'h0000_0080);
    end_of_test();
  end
endmodule
